// >>> pcw_pkg.sv
package pcw_pkg;
  localparam int NUM_MOD = 5;
  localparam int WDT_MOD = 4;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CNT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_MOD_BASE = 8'h20;
  localparam logic [7:0] OFS_MOD_STEP = 8'h08;
  localparam logic [7:0] OFS_MOD_CMP = 8'h04;
  // control and counter mode register fields
  localparam int CTRL_RUN_BIT = 6;
  localparam int MODE_WD_EN_BIT = 6;
  // module mode register fields
  localparam int MM_CMP_EN = 6;
  localparam int MM_MATCH_EN = 3;
  localparam int MM_TOGGLE = 2;
  localparam int MM_PWM = 1;
  localparam int MM_IRQ_EN = 0;
  localparam int MM_W = 7;
  localparam int MC_TICK_DIV = 12;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    PCW_OFF = 2'b00,
    PCW_TIMER = 2'b01,
    PCW_HSO = 2'b11,
    PCW_PWM = 2'b10
  } pcw_mode_t;
endpackage

// >>> pcw_tick.sv
module pcw_tick #(
  parameter int DIV = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  import pcw_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } pcw_tick_st_t;
  pcw_tick_st_t st_ff, nxt_st;
  localparam logic [7:0] LAST = 8'(DIV - 1);
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == LAST) begin
      nxt_st.cnt = 8'h00;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick = st_ff.tick;
endmodule

// >>> pcw_cmp.sv
module pcw_cmp (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic inc,
  input wire logic [15:0] cnt_next,
  input wire logic [6:0] mode_reg,
  input wire logic [15:0] cmp_val,
  input wire logic wd_en,
  output logic match,
  output logic pin_out,
  output logic [7:0] duty_active
);
  import pcw_pkg::*;
  typedef struct packed {
    logic pin;
    logic [7:0] duty;
    logic match;
  } pcw_cmp_st_t;
  pcw_cmp_st_t st_ff, nxt_st;
  pcw_mode_t mode;
  logic eq;
  always_comb begin
    if (mode_reg[MM_CMP_EN] && mode_reg[MM_PWM]) begin
      mode = PCW_PWM;
    end else if (mode_reg[MM_CMP_EN] && mode_reg[MM_MATCH_EN] && mode_reg[MM_TOGGLE]) begin
      mode = PCW_HSO;
    end else if (mode_reg[MM_CMP_EN] && mode_reg[MM_MATCH_EN]) begin
      mode = PCW_TIMER;
    end else begin
      mode = PCW_OFF;
    end
  end
  // compared once per counter step, on the value being loaded
  assign eq = inc && (cnt_next == cmp_val);
  always_comb begin
    nxt_st = st_ff;
    nxt_st.match = 1'b0;
    case (mode)
      PCW_TIMER: begin
        nxt_st.match = eq;
      end
      PCW_HSO: begin
        nxt_st.match = eq;
        if (eq) begin
          nxt_st.pin = ~st_ff.pin;
        end
      end
      PCW_PWM: begin
        if (inc && cnt_next[7:0] == 8'h00) begin
          nxt_st.duty = cmp_val[15:8];
          nxt_st.pin = (8'h00 >= cmp_val[15:8]);
        end else if (inc) begin
          nxt_st.pin = (cnt_next[7:0] >= st_ff.duty);
        end
      end
      default: begin
        nxt_st.match = 1'b0;
      end
    endcase
    if (wd_en && mode != PCW_PWM) begin
      nxt_st.match = eq;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.pin <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign match = st_ff.match;
  assign pin_out = st_ff.pin;
  assign duty_active = st_ff.duty;
endmodule

// >>> pcw_top.sv
// Functional notes
// - in timer mode each module compares the 16-bit counter with its compare value, flags equality, interrupts if enabled.
// - high-speed output mode needs toggle, match and comparator enable bits all set.
// - in high-speed output mode the pin inverts on each equality.
// - modulation mode needs modulation enable and comparator enable bits set.
// - all modulators share the one counter for period, each has its own duty.
// - modulator output is low while low counter byte is below active duty, high otherwise.
// - on low byte wrap from FF to 00 the reload byte is copied into the active duty byte.
// - watchdog exists only in module 4, which stays usable otherwise.
// - watchdog match on module 4 raises an internal reset, not the reset pin.
// - watchdog acts only while bit 6 of the counter mode register is set.
// - hardware sets the match flag; only software clears it.
// - the counter advances only while bit 6 of the control register is set.
module pcw_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [pcw_pkg::NUM_MOD-1:0] module_output_pin,
  output logic internal_reset,
  output logic irq
);
  import pcw_pkg::*;
  typedef struct packed {
    logic counter_run_bit;
    logic watchdog_function_enable;
    logic [15:0] cnt;
    logic [NUM_MOD-1:0] module_match_flag;
    logic [NUM_MOD-1:0] irq_stat;
    logic [NUM_MOD-1:0] irq_mask;
    logic [NUM_MOD*MM_W-1:0] mode;
    logic [NUM_MOD*16-1:0] cmp;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wd_reset;
  } pcw_st_t;
  pcw_st_t st_ff, nxt_st;
  logic tick;
  logic inc;
  logic [15:0] cnt_next;
  logic [NUM_MOD-1:0] match;
  logic [NUM_MOD-1:0] pin;

  // module index of an address in the per-module window, NUM_MOD if none
  function automatic logic [3:0] mod_index(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - OFS_MOD_BASE;
    if (a >= OFS_MOD_BASE && rel < 8'(NUM_MOD) * OFS_MOD_STEP) begin
      mod_index = 4'(rel / OFS_MOD_STEP);
    end else begin
      mod_index = 4'(NUM_MOD);
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // register picked by an address, shared by the write and read decoders
  typedef enum logic [2:0] {
    SEL_CTRL = 3'h0,
    SEL_MODE = 3'h1,
    SEL_CNT = 3'h2,
    SEL_STAT = 3'h3,
    SEL_MASK = 3'h4,
    SEL_MOD_MODE = 3'h5,
    SEL_MOD_CMP = 3'h6,
    SEL_NONE = 3'h7
  } pcw_sel_t;

  function automatic pcw_sel_t reg_sel(input logic [7:0] a);
    logic in_win;
    in_win = (mod_index(a) != 4'(NUM_MOD));
    if (a == OFS_CTRL) begin
      reg_sel = SEL_CTRL;
    end else if (a == OFS_MODE) begin
      reg_sel = SEL_MODE;
    end else if (a == OFS_CNT) begin
      reg_sel = SEL_CNT;
    end else if (a == OFS_IRQ_STAT) begin
      reg_sel = SEL_STAT;
    end else if (a == OFS_IRQ_MASK) begin
      reg_sel = SEL_MASK;
    end else if (in_win && a[2:0] == 3'h0) begin
      reg_sel = SEL_MOD_MODE;
    end else if (in_win && a[2:0] == OFS_MOD_CMP[2:0]) begin
      reg_sel = SEL_MOD_CMP;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  // software view of the control word; bits not named here read as zero
  function automatic logic [31:0] ctrl_image(input logic run, input logic [NUM_MOD-1:0] flags);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CTRL_RUN_BIT] = run;
    v[NUM_MOD-1:0] = flags;
    ctrl_image = v;
  endfunction

  function automatic logic [31:0] mode_image(input logic wd_on);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[MODE_WD_EN_BIT] = wd_on;
    mode_image = v;
  endfunction

  pcw_tick #(
    .DIV(MC_TICK_DIV)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  assign inc = tick && st_ff.counter_run_bit;
  assign cnt_next = st_ff.cnt + 16'h0001;

  genvar g;
  generate
    for (g = 0; g < NUM_MOD; g++) begin : g_mod
      pcw_cmp u_cmp (
        .aclk(aclk),
        .aresetn(aresetn),
        .inc(inc),
        .cnt_next(cnt_next),
        .mode_reg(st_ff.mode[g*MM_W +: MM_W]),
        .cmp_val(st_ff.cmp[g*16 +: 16]),
        .wd_en((g == WDT_MOD) && st_ff.watchdog_function_enable),
        .match(match[g]),
        .pin_out(pin[g]),
        .duty_active()
      );
    end
  endgenerate

  always_comb begin
    logic [31:0] wv;
    logic [31:0] rv;
    logic [3:0] mi;
    logic wr_ok;
    logic rd_ok;
    logic [NUM_MOD-1:0] flag_clr;
    logic stat_clr;
    wv = 32'h0000_0000;
    rv = 32'h0000_0000;
    mi = 4'h0;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    flag_clr = '0;
    stat_clr = 1'b0;
    nxt_st = st_ff;
    nxt_st.wd_reset = 1'b0;
    if (inc) begin
      nxt_st.cnt = cnt_next;
    end
    // write side
    if (s_axi_awvalid && !st_ff.aw_got) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_got) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      wr_ok = 1'b1;
      mi = mod_index(st_ff.aw_addr);
      case (reg_sel(st_ff.aw_addr))
        SEL_CTRL: begin
          wv = merge(ctrl_image(st_ff.counter_run_bit, st_ff.module_match_flag), st_ff.w_data, st_ff.w_strb);
          nxt_st.counter_run_bit = wv[CTRL_RUN_BIT];
          flag_clr = ~wv[NUM_MOD-1:0];
        end
        SEL_MODE: begin
          wv = merge(mode_image(st_ff.watchdog_function_enable), st_ff.w_data, st_ff.w_strb);
          nxt_st.watchdog_function_enable = wv[MODE_WD_EN_BIT];
        end
        SEL_MASK: begin
          wv = merge({27'h000_0000, st_ff.irq_mask}, st_ff.w_data, st_ff.w_strb);
          nxt_st.irq_mask = wv[NUM_MOD-1:0];
        end
        SEL_MOD_MODE: begin
          wv = merge({25'h000_0000, st_ff.mode[mi*MM_W +: MM_W]}, st_ff.w_data, st_ff.w_strb);
          nxt_st.mode[mi*MM_W +: MM_W] = wv[MM_W-1:0];
        end
        SEL_MOD_CMP: begin
          // software moves this value ahead of the counter for the watchdog
          wv = merge({16'h0000, st_ff.cmp[mi*16 +: 16]}, st_ff.w_data, st_ff.w_strb);
          nxt_st.cmp[mi*16 +: 16] = wv[15:0];
        end
        default: begin
          wr_ok = 1'b0; // counter and status are read-only, the rest unmapped
        end
      endcase
      nxt_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // read side
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      rd_ok = 1'b1;
      mi = mod_index(s_axi_araddr);
      case (reg_sel(s_axi_araddr))
        SEL_CTRL: begin
          rv = ctrl_image(st_ff.counter_run_bit, st_ff.module_match_flag);
        end
        SEL_MODE: begin
          rv = mode_image(st_ff.watchdog_function_enable);
        end
        SEL_CNT: begin
          rv = {16'h0000, st_ff.cnt};
        end
        SEL_STAT: begin
          rv = {27'h000_0000, st_ff.irq_stat};
          stat_clr = 1'b1;
        end
        SEL_MASK: begin
          rv = {27'h000_0000, st_ff.irq_mask};
        end
        SEL_MOD_MODE: begin
          rv = {25'h000_0000, st_ff.mode[mi*MM_W +: MM_W]};
        end
        SEL_MOD_CMP: begin
          rv = {16'h0000, st_ff.cmp[mi*16 +: 16]};
        end
        default: begin
          rd_ok = 1'b0;
        end
      endcase
      nxt_st.rdata = rv;
      nxt_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // set wins over clear
    nxt_st.module_match_flag = (st_ff.module_match_flag & ~flag_clr) | match;
    nxt_st.irq_stat = (stat_clr ? '0 : st_ff.irq_stat) | match;
    if (st_ff.watchdog_function_enable && match[WDT_MOD]) begin
      nxt_st.wd_reset = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  logic [NUM_MOD-1:0] mod_irq;
  generate
    for (g = 0; g < NUM_MOD; g++) begin : g_irq
      assign mod_irq[g] = st_ff.module_match_flag[g] && st_ff.mode[g*MM_W + MM_IRQ_EN];
    end
  endgenerate

  assign s_axi_awready = !st_ff.aw_got;
  assign s_axi_wready = !st_ff.w_got;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign module_output_pin = pin;
  assign internal_reset = st_ff.wd_reset;
  assign irq = |(st_ff.irq_stat & st_ff.irq_mask) || |mod_irq;
endmodule

// >>> pcw_pin_load.sv
module pcw_pin_load (
  input wire logic aclk,
  input wire logic clr,
  input wire logic [4:0] pin,
  output logic [15:0] hi [5],
  output logic [15:0] tg [5]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] last;
  // counts high cycles and level changes per pin since the last clear
  always @(posedge aclk) begin
    last <= pin;
    for (int i = 0; i < 5; i++) begin
      hi[i] <= clr ? 16'h0 : hi[i] + 16'(pin[i]);
      tg[i] <= clr ? 16'h0 : tg[i] + 16'(pin[i] ^ last[i]);
    end
  end
endmodule

// >>> pcw_sva.sv
module pcw_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic internal_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcw_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_t;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_t;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  resp_hold_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped early");
  rd_hold_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped early");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  rd_answer_a: assert property (ar_t |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (wr_t |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
  unmapped_rd_a: assert property (ar_t ##0 s_axi_araddr == 8'h18 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  wd_pulse_a: assert property (internal_reset |=> !internal_reset [*8])
    else $error("watchdog reset pulse too long");
endmodule
bind pcw_top pcw_sva u_pcw_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .internal_reset);

// >>> test_pca_compare_pwm_watchdog_modes.sv
module test_pca_compare_pwm_watchdog_modes;
  timeunit 1ns;
  timeprecision 1ns;
  import pcw_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, internal_reset, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] module_output_pin;
  logic [15:0] hi [5];
  logic [15:0] tg [5];
  int n_fail, comparisons, n_wd;
  pcw_top u_pcw_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .module_output_pin,
    .internal_reset, .irq);
  pcw_pin_load u_pcw_pin_load (.aclk, .clr, .pin(module_output_pin), .hi, .tg);
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    #800000;
    n_fail++;
    test_done;
  end
  always @(posedge aclk) if (internal_reset === 1'h1) n_wd++;
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid) break;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    ck(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  function automatic logic [7:0] ma(input int n);
    return OFS_MOD_BASE + OFS_MOD_STEP * 8'(n);
  endfunction
  task automatic t_timer;
    cyc(30);
    rd(OFS_CNT);
    ck(d, 32'h0);
    wr(ma(0) + OFS_MOD_CMP, 32'h0003);
    wr(ma(0), 32'h0049);
    wr(OFS_CTRL, 32'h0040);
    for (int i = 0; i < 100 && irq !== 1'h1; i++) @(posedge aclk);
    rd(OFS_CNT);
    ck(d, 32'h0003);
    wr(OFS_CTRL, 32'h0001);
    rd(OFS_CTRL);
    ck(d, 32'h0001);
    ck(irq, 1'h1);
    wr(OFS_CTRL, 32'h0000);
    cyc(2);
    ck(irq, 1'h0);
    wr(OFS_IRQ_MASK, 32'h0001);
    cyc(2);
    ck(irq, 1'h1);
    rd(OFS_IRQ_STAT);
    ck(d, 32'h0001);
    cyc(2);
    ck(irq, 1'h0);
    rd(OFS_IRQ_STAT);
    ck(d, 32'h0000);
    wr(8'h18, 32'h0001, RESP_SLVERR);
    rd(8'h18);
    ck(r, RESP_SLVERR);
    $display("timer test done");
  endtask
  task automatic t_hso;
    rd(OFS_CNT);
    wr(ma(1) + OFS_MOD_CMP, d + 2);
    wr(ma(2) + OFS_MOD_CMP, d + 2);
    wr(ma(1), 32'h004C);
    wr(ma(2), 32'h0044);
    clr <= 1'h1;
    @(posedge aclk);
    clr <= 1'h0;
    wr(OFS_CTRL, 32'h0040);
    cyc(60);
    ck(tg[1], 16'h1);
    ck(module_output_pin[1], 1'h0);
    ck(tg[2], 16'h0);
    $display("high speed output test done");
  endtask
  task automatic t_pwm;
    logic [15:0] rl [3] = '{16'h4000, 16'hC000, 16'h8000};
    int m [3] = '{0, 3, 4};
    for (int i = 0; i < 3; i++) begin
      wr(ma(m[i]) + OFS_MOD_CMP, rl[i]);
      wr(ma(m[i]), 32'h0042);
    end
    wr(ma(2), 32'h0002);
    cyc(3100);
    clr <= 1'h1;
    @(posedge aclk);
    clr <= 1'h0;
    cyc(3073);
    for (int i = 0; i < 3; i++) begin
      ck(hi[m[i]], (256 - rl[i][15:8]) * MC_TICK_DIV);
      ck(tg[m[i]], 16'h2);
    end
    ck(tg[2], 16'h0);
    ck(hi[2], 256 * MC_TICK_DIV);
    $display("pwm test done");
  endtask
  task automatic t_wdog;
    rd(OFS_CNT);
    wr(ma(4) + OFS_MOD_CMP, d + 100);
    wr(ma(4), 32'h0048);
    wr(OFS_MODE, 32'h0040);
    n_wd = 0;
    cyc(80);
    ck(n_wd, 0);
    rd(OFS_CNT);
    wr(ma(4) + OFS_MOD_CMP, d + 4);
    cyc(80);
    ck(n_wd, 1);
    wr(OFS_MODE, 32'h0000);
    rd(OFS_CNT);
    wr(ma(4) + OFS_MOD_CMP, d + 4);
    cyc(80);
    ck(n_wd, 1);
    $display("watchdog test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clr} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    comparisons = 0;
    n_wd = 0;
    cyc(4);
    aresetn <= 1'h1;
    t_timer;
    t_hso;
    t_pwm;
    t_wdog;
    test_done;
  end
endmodule
